// File: hw/ipc_link_master.sv
`include "ipc_master_defines.svh"

module ipc_link_master
    import ipc_master_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic START,
    input wire logic [15:0] PAYLOAD_BYTES,
    input wire logic HOLD_READY,
    input wire logic TX_VALID,
    input wire logic [7:0] TX_DATA,
    output logic TX_READY,
    output logic RX_VALID,
    output logic [7:0] RX_DATA,
    output logic BUSY,
    output logic FRAME_DONE,
    output logic MORE_SEEN,
    output logic SLAVE_WAKE,
    output logic SPI_CLK,
    output logic MOSI,
    input wire logic MISO,
    output logic MASTER_READY_LINE,
    input wire logic SLAVE_READY_LINE
);
    state_type state_reg, state_next;
    logic [15:0] count_reg, count_next;
    logic [15:0] total_reg, total_next;
    logic [3:0] lead_reg, lead_next;
    logic mrdy_reg, mrdy_next;
    logic done_reg, done_next;
    logic more_reg, more_next;
    logic [7:0] rxd_reg, rxd_next;
    logic rxv_reg, rxv_next;
    logic [1:0] miso_sr, srdy_sr;
    logic srdy_d_reg;
    logic run;
    logic miso_s, srdy_s;
    ipc_byte_if bif ();

    // Two stage synchronisers; only the second stage is read by logic.
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            miso_sr <= 2'h3;
            srdy_sr <= 2'h0;
            srdy_d_reg <= 1'b0;
        end
        else
        begin
            miso_sr <= {miso_sr[0], MISO};
            srdy_sr <= {srdy_sr[0], SLAVE_READY_LINE};
            srdy_d_reg <= srdy_sr[1];
        end
    end
    assign miso_s = miso_sr[1];
    assign srdy_s = srdy_sr[1];

    function automatic logic [15:0] round4(input logic [15:0] n);
        round4 = {n[15:2] + {13'h0, |n[1:0]}, 2'h0};
    endfunction : round4

    assign run = (state_reg == ST_SHIFT);
    assign bif.tx_valid = run && TX_VALID;
    assign bif.tx_data = TX_DATA;
    assign TX_READY = run && bif.tx_ready;

    ipc_byte_shifter u_shift (
        .clk(REF_CLK),
        .rstn(RSTN),
        .run(run),
        .miso_sync(miso_s),
        .bus(bif),
        .sclk(SPI_CLK),
        .mosi(MOSI)
    );

    always_comb
    begin
        state_next = state_reg;
        count_next = count_reg;
        total_next = total_reg;
        lead_next = lead_reg;
        mrdy_next = mrdy_reg;
        done_next = 1'b0;
        more_next = more_reg;
        rxv_next = bif.rx_valid;
        rxd_next = bif.rx_valid ? bif.rx_data : rxd_reg;
        unique case (state_reg)
            ST_IDLE:
            begin
                // Rising our ready line also wakes an idle device.
                if (START || (srdy_s && HOLD_READY))
                begin
                    // Frame length fixed before the packet: header plus padded payload.
                    total_next = `HEADER_BYTES + round4((PAYLOAD_BYTES > `MAX_FRAME_BYTES - `HEADER_BYTES) ?
                        `MAX_FRAME_BYTES - `HEADER_BYTES : PAYLOAD_BYTES);
                    count_next = 16'h0000;
                    more_next = 1'b0;
                    mrdy_next = 1'b1;
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                // Wait for the device's readiness interrupt before clocking.
                lead_next = 4'h0;
                if (srdy_s)
                begin
                    state_next = ST_LEAD;
                end
            end
            ST_LEAD:
            begin
                lead_next = lead_reg + 4'h1;
                if (!srdy_s)
                begin
                    state_next = ST_WAIT;
                end
                else if (lead_reg == `START_DELAY_CYCLES - 4'h1)
                begin
                    state_next = ST_SHIFT;
                end
            end
            ST_SHIFT:
            begin
                if (bif.rx_valid)
                begin
                    // Header byte 0 carries the more-data flag from the device.
                    if (count_reg == 16'h0000 && bif.rx_data[`HDR_MORE_BIT - 24])
                    begin
                        more_next = 1'b1;
                    end
                    count_next = count_reg + 16'h0001;
                    // One byte in per byte out; stop clocking exactly at frame end.
                    if (count_reg + 16'h0001 == total_reg)
                    begin
                        state_next = ST_DONE;
                    end
                end
            end
            ST_DONE:
            begin
                done_next = 1'b1;
                // Clock is already idle here; keep ready high if more packets follow.
                mrdy_next = HOLD_READY || more_reg;
                state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            state_reg <= ST_IDLE;
            count_reg <= 16'h0000;
            total_reg <= 16'h0000;
            lead_reg <= 4'h0;
            mrdy_reg <= 1'b0;
            done_reg <= 1'b0;
            more_reg <= 1'b0;
            rxv_reg <= 1'b0;
            rxd_reg <= 8'h00;
        end
        else
        begin
            state_reg <= state_next;
            count_reg <= count_next;
            total_reg <= total_next;
            lead_reg <= lead_next;
            mrdy_reg <= mrdy_next;
            done_reg <= done_next;
            more_reg <= more_next;
            rxv_reg <= rxv_next;
            rxd_reg <= rxd_next;
        end
    end

    assign MASTER_READY_LINE = mrdy_reg;
    assign BUSY = (state_reg != ST_IDLE);
    assign FRAME_DONE = done_reg;
    assign MORE_SEEN = more_reg;
    assign RX_VALID = rxv_reg;
    assign RX_DATA = rxd_reg;
    // Device readiness while we are idle is its wake-up request.
    assign SLAVE_WAKE = srdy_s && !srdy_d_reg && (state_reg == ST_IDLE);

    AST_NO_CLOCK_WITHOUT_READY: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        $rose(SPI_CLK) |-> (mrdy_reg && state_reg == ST_SHIFT))
        else $error("Clock edge without both ready.");
    AST_READY_BEFORE_CLOCK: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (state_reg == ST_WAIT && srdy_s) |=> ##1 (state_reg == ST_LEAD || state_reg == ST_WAIT))
        else $error("Lead-in skipped.");
    AST_LEAD_LENGTH: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (state_reg == ST_WAIT) ##1 (state_reg == ST_LEAD) [*2] |=> (state_reg == ST_SHIFT || !srdy_sr[1]))
        else $error("Lead-in length wrong.");
    AST_FRAME_MULT4: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (state_reg == ST_SHIFT) |-> (total_reg[1:0] == 2'h0 && total_reg >= `HEADER_BYTES))
        else $error("Frame length not a multiple of four.");
    AST_EXACT_BYTES: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (state_reg == ST_DONE) |-> (count_reg == total_reg))
        else $error("Byte count differs from frame length.");
    AST_CLOCK_IDLE_AT_END: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (state_reg == ST_DONE) |-> !SPI_CLK)
        else $error("Clock not idle at frame end.");
    AST_DONE_PULSE: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (state_reg == ST_DONE) |=> (FRAME_DONE && state_reg == ST_IDLE))
        else $error("Frame done not signalled.");
    AST_READY_DURING_FRAME: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (state_reg == ST_SHIFT) |-> mrdy_reg)
        else $error("Master ready dropped mid frame.");
endmodule : ipc_link_master

// File: include/ipc_master_defines.svh
`ifndef IPC_MASTER_DEFINES_SVH
`define IPC_MASTER_DEFINES_SVH
// Operation
// - Clock idles low, master drives it.
// - Every byte travels most significant bit first.
// - Both readiness lines idle low.
// - Four byte header, payload in four-byte steps.
// - Frame length known before each packet.
// - Full duplex, equal byte counts both ways.
// - Each side raises readiness when ready.
// - Wait for other readiness before transfer.
// - Clock starts only once both lines active.
// - Exactly as many clocks as frame needs.
// - Master ready drops after final clock idle.
// - Rising master ready wakes an idle device.
// - Plain one-master exchange, no chip select.
// - More-data flag repeats exchange on readiness; code only keeps master ready high, repeat needs START or HOLD_READY.
// - Master ready may stay high between frames.
// - Master raises ready again if device ready; code does so only with HOLD_READY, else pulses SLAVE_WAKE.

// Half a link clock period in reference clock cycles.
`define SCLK_HALF_CYCLES 4'h2
// Lead-in cycles from both lines active to the start of shifting; the first clock edge comes later.
`define START_DELAY_CYCLES 4'h2
// Header layout: bit 31 is more-data, bits 15..0 payload byte count.
`define HDR_MORE_BIT 31
`define HDR_LEN_MSB 15
`define HEADER_BYTES 16'h0004
`define MAX_FRAME_BYTES 16'hFFFC
`endif

// File: include/ipc_master_pkg.sv
package ipc_master_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_WAIT = 5'h02,
        ST_LEAD = 5'h04,
        ST_SHIFT = 5'h08,
        ST_DONE = 5'h10
    } state_type;

    typedef logic [7:0] byte_type;
endpackage : ipc_master_pkg

// File: include/ipc_byte_if.sv
interface ipc_byte_if;
    logic tx_valid;
    logic tx_ready;
    logic [7:0] tx_data;
    logic rx_valid;
    logic [7:0] rx_data;
    modport core (output tx_valid, output tx_data, input tx_ready, input rx_valid, input rx_data);
    modport shifter (input tx_valid, input tx_data, output tx_ready, output rx_valid, output rx_data);
endinterface : ipc_byte_if

// File: hw/ipc_byte_shifter.sv
`include "ipc_master_defines.svh"

module ipc_byte_shifter
    import ipc_master_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic miso_sync,
    ipc_byte_if.shifter bus,
    output logic sclk,
    output logic mosi
);
    logic [3:0] div_reg, div_next;
    logic sclk_reg, sclk_next;
    logic [7:0] tx_reg, tx_next;
    logic [7:0] rx_reg, rx_next;
    logic [2:0] bit_reg, bit_next;
    logic loaded_reg, loaded_next;
    logic rxv_reg, rxv_next;
    logic [7:0] rxd_reg, rxd_next;
    logic cap_reg, cap_next;
    logic tick;

    assign tick = (div_reg == `SCLK_HALF_CYCLES - 4'h1);
    assign bus.tx_ready = run && !loaded_reg;
    assign bus.rx_valid = rxv_reg;
    assign bus.rx_data = rxd_reg;
    assign sclk = sclk_reg;
    assign mosi = tx_reg[7];

    always_comb
    begin
        div_next = (run && loaded_reg && !tick) ? div_reg + 4'h1 : 4'h0;
        sclk_next = sclk_reg;
        tx_next = tx_reg;
        rx_next = rx_reg;
        bit_next = bit_reg;
        loaded_next = loaded_reg;
        rxv_next = 1'b0;
        rxd_next = rxd_reg;
        cap_next = 1'b0;
        if (bus.tx_valid && bus.tx_ready)
        begin
            tx_next = bus.tx_data;
            loaded_next = 1'b1;
            bit_next = 3'h0;
        end
        else if (run && loaded_reg && tick)
        begin
            sclk_next = !sclk_reg;
            if (!sclk_reg)
            begin
                // Both sides move their data on the rising edge, so it stands across the falling one.
                // The first bit is preloaded, so the first rising edge keeps it.
                if (bit_reg != 3'h0)
                begin
                    tx_next = {tx_reg[6:0], 1'b1};
                end
            end
            else
            begin
                bit_next = bit_reg + 3'h1;
                cap_next = 1'b1;
            end
        end
        else if (cap_reg)
        begin
            // The synchroniser lags two cycles, so the bit moved out on the rising edge is taken just after
            // our falling edge; this needs a half period of at least two cycles.
            rx_next = {rx_reg[6:0], miso_sync};
            if (bit_reg == 3'h0)
            begin
                loaded_next = 1'b0;
                rxv_next = 1'b1;
                rxd_next = {rx_reg[6:0], miso_sync};
            end
        end
        if (!run)
        begin
            sclk_next = 1'b0;
            loaded_next = 1'b0;
            cap_next = 1'b0;
            tx_next = 8'hFF;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            div_reg <= 4'h0;
            sclk_reg <= 1'b0;
            tx_reg <= 8'hFF;
            rx_reg <= 8'h00;
            bit_reg <= 3'h0;
            loaded_reg <= 1'b0;
            rxv_reg <= 1'b0;
            rxd_reg <= 8'h00;
            cap_reg <= 1'b0;
        end
        else
        begin
            div_reg <= div_next;
            sclk_reg <= sclk_next;
            tx_reg <= tx_next;
            rx_reg <= rx_next;
            bit_reg <= bit_next;
            loaded_reg <= loaded_next;
            rxv_reg <= rxv_next;
            rxd_reg <= rxd_next;
            cap_reg <= cap_next;
        end
    end

    AST_SCLK_IDLE_LOW: assert property (@(posedge clk) disable iff (!rstn) !run |=> !sclk_reg)
        else $error("Link clock not low while idle.");
    AST_MOSI_IDLE_HIGH: assert property (@(posedge clk) disable iff (!rstn) !run |=> tx_reg[7])
        else $error("Master data not high while idle.");
endmodule : ipc_byte_shifter

// File: dv/ipc_device_model.sv
module ipc_device_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic spi_clk,
    input wire logic mosi,
    input wire logic master_ready_line,
    input wire logic push,
    input wire logic [15:0] frame_len,
    input wire logic [7:0] tx_base,
    input wire logic [7:0] lag,
    output logic miso,
    output logic slave_ready_line,
    output logic [7:0] rx_last,
    output logic [15:0] bit_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic mr_q;
    logic [1:0] mr_sync;
    logic more_q;
    logic [7:0] rx_sh;
    logic [7:0] cur;

    // The device answers the first frame after reset with no set-up of any kind.
    initial
    begin
        slave_ready_line = 1'b0;
        miso = 1'b1;
        mr_q = 1'b0;
        mr_sync = 2'h0;
        more_q = 1'b0;
        rx_sh = 8'h00;
        rx_last = 8'h00;
        bit_cnt = 16'h0000;
        wait (rstn === 1'b1);
        forever
        begin
            @(posedge clk);
            // Ready comes only on a wake edge, pending data or a flagged follow-up, otherwise it idles.
            if (!slave_ready_line && (push || more_q || (mr_sync[1] && !mr_q)))
            begin
                more_q = 1'b0;
                repeat (lag) @(posedge clk);
                bit_cnt = 16'h0000;
                slave_ready_line <= 1'b1;
            end
            mr_q = mr_sync[1];
        end
    end

    // The wake line is brought into the device's clock through two flops before it is judged.
    always @(posedge clk)
        mr_sync <= {mr_sync[0], master_ready_line};

    always @(posedge spi_clk)
    begin
        cur = tx_base + bit_cnt[10:3];
        miso <= cur[3'h7 - bit_cnt[2:0]];
    end

    // The master moves its data on rising edges, so it stands still across the falling edge.
    always @(negedge spi_clk)
    begin
        rx_sh = {rx_sh[6:0], mosi};
        bit_cnt = bit_cnt + 16'h0001;
        if (bit_cnt[2:0] == 3'h0)
            rx_last <= rx_sh;
        if (bit_cnt == {frame_len[12:0], 3'h0})
        begin
            slave_ready_line <= 1'b0;
            miso <= 1'b1;
            more_q = tx_base[7];
        end
    end
endmodule : ipc_device_model

// File: dv/ipc_link_master_tb_top.sv
module ipc_link_master_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic REF_CLK = 1'b0;
    logic RSTN = 1'b0;
    logic START = 1'b0;
    logic [15:0] PAYLOAD_BYTES = 16'h0000;
    logic HOLD_READY = 1'b0;
    logic TX_VALID = 1'b0;
    logic [7:0] TX_DATA = 8'h00;
    logic TX_READY, RX_VALID, BUSY, FRAME_DONE, MORE_SEEN, SLAVE_WAKE, SPI_CLK, MOSI, MISO;
    logic MASTER_READY_LINE, SLAVE_READY_LINE;
    logic [7:0] RX_DATA;
    logic push = 1'b0;
    logic [15:0] dev_len = 16'h0004;
    logic [7:0] dev_base = 8'h00;
    logic [7:0] dev_lag = 8'h02;
    logic [7:0] dev_rx_last;
    logic [15:0] dev_bits;
    int error_cnt = 0;
    int num_checks = 0;

    always #50 REF_CLK = ~REF_CLK;

    ipc_link_master uut (.REF_CLK, .RSTN, .START, .PAYLOAD_BYTES, .HOLD_READY, .TX_VALID, .TX_DATA, .TX_READY,
        .RX_VALID, .RX_DATA, .BUSY, .FRAME_DONE, .MORE_SEEN, .SLAVE_WAKE, .SPI_CLK, .MOSI, .MISO,
        .MASTER_READY_LINE, .SLAVE_READY_LINE);

    ipc_device_model dev (.clk(REF_CLK), .rstn(RSTN), .spi_clk(SPI_CLK), .mosi(MOSI),
        .master_ready_line(MASTER_READY_LINE), .push(push), .frame_len(dev_len), .tx_base(dev_base),
        .lag(dev_lag), .miso(MISO), .slave_ready_line(SLAVE_READY_LINE), .rx_last(dev_rx_last), .bit_cnt(dev_bits));

    task end_of_test;
        if (error_cnt == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Header: first byte carries the more flag (clear here), last two the payload length.
    function automatic logic [7:0] hb(input logic [15:0] i, input logic [15:0] len);
        logic [15:0] pl;
        pl = len - 16'h0004;
        case (i)
            16'h0000, 16'h0001: hb = 8'h00;
            16'h0002: hb = pl[15:8];
            16'h0003: hb = pl[7:0];
            default: hb = 8'hC1 + i[7:0];
        endcase
    endfunction : hb

    task run_frame(input logic [15:0] pay, input logic [7:0] base, input logic hold);
        logic [15:0] len;
        logic [15:0] idx;
        logic [15:0] rxi;
        logic take;
        logic done;
        int t;
        len = ((pay + 16'h0003) & 16'hFFFC) + 16'h0004;
        idx = 16'h0000;
        rxi = 16'h0000;
        done = 1'b0;
        @(posedge REF_CLK);
        dev_base <= base;
        dev_len <= len;
        HOLD_READY <= hold;
        PAYLOAD_BYTES <= pay;
        START <= 1'b1;
        TX_VALID <= 1'b1;
        TX_DATA <= hb(16'h0000, len);
        @(posedge REF_CLK);
        START <= 1'b0;
        @(posedge REF_CLK);
        @(negedge REF_CLK);
        chk(MASTER_READY_LINE, 16'h0001);
        for (t = 0; t < 4000 && !done; t++)
        begin
            @(negedge REF_CLK);
            if (SLAVE_READY_LINE !== 1'b1 && rxi == 16'h0000)
                chk(SPI_CLK, 16'h0000);
            if (RX_VALID === 1'b1)
            begin
                chk(RX_DATA, 8'(base + rxi[7:0]));
                rxi = rxi + 16'h0001;
            end
            take = (TX_VALID === 1'b1) && (TX_READY === 1'b1);
            done = (FRAME_DONE === 1'b1);
            @(posedge REF_CLK);
            // A second start in mid-frame must be ignored.
            START <= (idx == 16'h0002);
            if (take)
            begin
                idx = idx + 16'h0001;
                TX_DATA <= hb(idx, len);
                TX_VALID <= (idx < len);
            end
        end
        if (!done)
        begin
            error_cnt = error_cnt + 1;
            end_of_test();
        end
        START <= 1'b0;
        chk(rxi, len);
        chk(dev_bits, {len[12:0], 3'h0});
        chk(dev_rx_last, hb(len - 16'h0001, len));
        chk(MORE_SEEN, base[7]);
        repeat (4) @(negedge REF_CLK);
        if (!base[7])
            chk(BUSY, 16'h0000);
        chk(SPI_CLK, 16'h0000);
        chk(MOSI, 16'h0001);
        chk(MASTER_READY_LINE, hold | base[7]);
    endtask : run_frame

    task slave_wake;
        logic seen;
        int t;
        seen = 1'b0;
        @(posedge REF_CLK);
        HOLD_READY <= 1'b0;
        dev_lag <= 8'h05;
        dev_len <= 16'h0008;
        push <= 1'b1;
        @(posedge REF_CLK);
        push <= 1'b0;
        for (t = 0; t < 200 && !seen; t++)
        begin
            @(negedge REF_CLK);
            seen = (SLAVE_WAKE === 1'b1);
        end
        chk(seen, 16'h0001);
        if (!seen)
            end_of_test();
        chk(MASTER_READY_LINE, 16'h0000);
        run_frame(16'h0004, 8'h41, 1'b0);
    endtask : slave_wake

    initial
    begin
        repeat (8) @(posedge REF_CLK);
        RSTN <= 1'b1;
        @(negedge REF_CLK);
        chk(SPI_CLK, 16'h0000);
        chk(MOSI, 16'h0001);
        chk(MASTER_READY_LINE, 16'h0000);
        chk(BUSY, 16'h0000);
        run_frame(16'h0000, 8'h15, 1'b0);
        dev_lag <= 8'h1E;
        run_frame(16'h0006, 8'hA3, 1'b0);
        run_frame(16'h0006, 8'h27, 1'b0);
        slave_wake();
        run_frame(16'h0008, 8'h5C, 1'b1);
        end_of_test();
    end
endmodule : ipc_link_master_tb_top
